// *** hw/rcrfp_parser.sv ***
`timescale 1ns/1ps
`include "rcrfp_defs.svh"
// What this block does
// - Type byte 0x17 marks a remote parameter set or query request.
// - Byte 4 is an echoed frame identifier; zero means no response.
// - Bytes 5 to 12 are the 64-bit destination, MSB first; zero is coordinator.
// - Option bit 0x01 disables the over-the-air acknowledgement.
// - Option bit 0x40 selects the extended transmission timeout.
// - Bytes 16 and 17 hold the two-character parameter command name.
// - Bytes from 18 are the value to write; none means a query.
// - Type byte 0x21 marks a source route installation request.
// - Route destination 0x000000000000FFFF means broadcast.
// - Hop count zero or above 40 discards the route frame and pulses frame_drop.
// - Route frames with more than 11 hops are also discarded.
// - Hops from byte 17 as 16-bit pairs, destination neighbour first.
module rcrfp_parser (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_byte,
   output logic             rem_valid,
   output logic [7:0]       rem_frame_id,
   output logic             rem_respond,
   output logic [63:0]      rem_dest64,
   output logic             rem_to_coord,
   output logic [15:0]      rem_dest16,
   output logic             rem_no_ack,
   output logic             rem_ext_timeout,
   output logic [15:0]      rem_cmd_name,
   output logic             rem_is_query,
   output logic             par_valid,
   output logic [7:0]       par_byte,
   output logic             par_last,
   output logic             route_valid,
   output logic [63:0]      route_dest64,
   output logic             route_bcast,
   output logic [15:0]      route_dest16,
   output logic [7:0]       route_nhops,
   output logic [175:0]     route_hops,
   output logic             frame_drop
);
   rcrfp_pkg::rcrfp_state_t state_reg, state_next;
   logic [15:0]  len_reg;
   logic [15:0]  idx_reg;
   logic [7:0]   sum_reg;
   logic [7:0]   type_reg;
   logic [7:0]   id_reg;
   logic [7:0]   opt_reg;
   logic [7:0]   nhops_reg;
   logic [63:0]  a64_reg;
   logic [15:0]  a16_reg;
   logic [15:0]  cmd_reg;
   logic [15:0]  hops_reg [0:10];
   logic         hop_ovf_reg;

   function automatic logic [7:0] rcrfp_csum(input logic [7:0] s);
      return 8'(`RCRFP_CSUM_BASE - s);
   endfunction : rcrfp_csum

   // Offset of the current body byte counted from the delimiter at 0
   wire logic [15:0] offs       = 16'(idx_reg + `RCRFP_OFF_TYPE);
   wire logic        take       = rx_valid;
   wire logic        body_last  = (idx_reg == 16'(len_reg - 16'h0001));
   wire logic        is_remote  = (type_reg == `RCRFP_TYPE_REMOTE);
   wire logic        is_route   = (type_reg == `RCRFP_TYPE_ROUTE);
   wire logic        in_a64     = (offs >= `RCRFP_OFF_A64_LO) && (offs <= `RCRFP_OFF_A64_HI);
   wire logic [15:0] hop_off    = 16'(offs - `RCRFP_OFF_HOP0);
   wire logic        in_hops    = is_route && (offs >= `RCRFP_OFF_HOP0);
   wire logic [3:0]  hop_idx    = hop_off[`RCRFP_HOP_IDX_W:1];
   wire logic        hop_fits   = (hop_off[15:1] < 15'(`RCRFP_MAX_HOPS));
   wire logic        csum_ok    = (rx_byte == rcrfp_csum(sum_reg));
   wire logic        rem_len_ok = (len_reg >= 16'(`RCRFP_OFF_PARAM - `RCRFP_OFF_TYPE));
   wire logic        route_len_ok = (len_reg
                                     == 16'(`RCRFP_ROUTE_BASE_LEN + {7'h00, nhops_reg, 1'b0}));
   wire logic        hops_ok    = (nhops_reg != 8'h00)
                                  && (nhops_reg <= `RCRFP_TABLE_SIZE)
                                  && (nhops_reg <= `RCRFP_MAX_HOPS);
   wire logic        frame_end  = (state_reg == rcrfp_pkg::RCRFP_CSUM) && take;
   wire logic        rem_ok     = frame_end && csum_ok && is_remote && rem_len_ok;
   wire logic        route_ok   = frame_end && csum_ok && is_route && route_len_ok
                                  && hops_ok && !hop_ovf_reg;
   // Parameter bytes stream out as they arrive; par_last marks the last one
   wire logic        par_now    = (state_reg == rcrfp_pkg::RCRFP_BODY) && take
                                  && is_remote && (offs >= `RCRFP_OFF_PARAM);

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         rcrfp_pkg::RCRFP_IDLE: if (take && rx_byte == `RCRFP_DELIM) state_next = rcrfp_pkg::RCRFP_LENH;
         rcrfp_pkg::RCRFP_LENH: if (take) state_next = rcrfp_pkg::RCRFP_LENL;
         rcrfp_pkg::RCRFP_LENL: if (take) begin
            state_next = ({len_reg[15:8], rx_byte} == 16'h0000) ? rcrfp_pkg::RCRFP_IDLE
                                                                 : rcrfp_pkg::RCRFP_BODY;
         end
         rcrfp_pkg::RCRFP_BODY: if (take && body_last) state_next = rcrfp_pkg::RCRFP_CSUM;
         rcrfp_pkg::RCRFP_CSUM: if (take) state_next = rcrfp_pkg::RCRFP_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg <= rcrfp_pkg::RCRFP_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Field capture; any byte taken while idle clears only the index, sum and hop overflow flag, other fields hold until overwritten
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         len_reg     <= 16'h0000;
         idx_reg     <= 16'h0000;
         sum_reg     <= 8'h00;
         type_reg    <= 8'h00;
         id_reg      <= 8'h00;
         opt_reg     <= 8'h00;
         nhops_reg   <= 8'h00;
         a64_reg     <= 64'h0000_0000_0000_0000;
         a16_reg     <= 16'h0000;
         cmd_reg     <= 16'h0000;
         hop_ovf_reg <= 1'b0;
      end else if (take) begin
         unique case (state_reg)
            rcrfp_pkg::RCRFP_IDLE: begin
               idx_reg     <= 16'h0000;
               sum_reg     <= 8'h00;
               hop_ovf_reg <= 1'b0;
            end
            rcrfp_pkg::RCRFP_LENH: len_reg <= {rx_byte, 8'h00};
            rcrfp_pkg::RCRFP_LENL: len_reg <= {len_reg[15:8], rx_byte};
            rcrfp_pkg::RCRFP_BODY: begin
               idx_reg <= 16'(idx_reg + 16'h0001);
               sum_reg <= 8'(sum_reg + rx_byte);
               if (idx_reg == 16'h0000) type_reg <= rx_byte;
               if (offs == `RCRFP_OFF_ID) id_reg <= rx_byte;
               if (in_a64) a64_reg <= {a64_reg[55:0], rx_byte};
               if (offs == `RCRFP_OFF_A16_HI) a16_reg[15:8] <= rx_byte;
               if (offs == `RCRFP_OFF_A16_LO) a16_reg[7:0] <= rx_byte;
               if (offs == `RCRFP_OFF_OPT) opt_reg <= rx_byte;
               if (offs == `RCRFP_OFF_CMD0) cmd_reg[15:8] <= rx_byte;
               if (offs == `RCRFP_OFF_CMD1) cmd_reg[7:0] <= rx_byte;
               if (offs == `RCRFP_OFF_NHOPS) nhops_reg <= rx_byte;
               if (in_hops && !hop_fits) hop_ovf_reg <= 1'b1;
            end
            rcrfp_pkg::RCRFP_CSUM: ;
         endcase
      end
   end

   // Hop table; first slot is the destination's neighbour
   always_ff @(posedge clk) begin
      if (take && state_reg == rcrfp_pkg::RCRFP_BODY && in_hops && hop_fits) begin
         if (!hop_off[0]) hops_reg[hop_idx][15:8] <= rx_byte;
         else hops_reg[hop_idx][7:0] <= rx_byte;
      end
   end

   wire logic [175:0] hops_flat;
   for (genvar g = 0; g < 11; g++) begin : g_flat
      assign hops_flat[g*16 +: 16] = hops_reg[g];
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rem_valid       <= 1'b0;
         rem_frame_id    <= 8'h00;
         rem_respond     <= 1'b0;
         rem_dest64      <= 64'h0000_0000_0000_0000;
         rem_to_coord    <= 1'b0;
         rem_dest16      <= 16'h0000;
         rem_no_ack      <= 1'b0;
         rem_ext_timeout <= 1'b0;
         rem_cmd_name    <= 16'h0000;
         rem_is_query    <= 1'b0;
         par_valid       <= 1'b0;
         par_byte        <= 8'h00;
         par_last        <= 1'b0;
         route_valid     <= 1'b0;
         route_dest64    <= 64'h0000_0000_0000_0000;
         route_bcast     <= 1'b0;
         route_dest16    <= 16'h0000;
         route_nhops     <= 8'h00;
         route_hops      <= 176'h0;
         frame_drop      <= 1'b0;
      end else begin
         rem_valid   <= rem_ok;
         route_valid <= route_ok;
         frame_drop  <= frame_end && !rem_ok && !route_ok;
         par_valid   <= par_now;
         par_byte    <= rx_byte;
         par_last    <= par_now && body_last;
         if (rem_ok) begin
            rem_frame_id    <= id_reg;
            rem_respond     <= (id_reg != 8'h00);
            rem_dest64      <= a64_reg;
            rem_to_coord    <= (a64_reg == 64'h0000_0000_0000_0000);
            rem_dest16      <= a16_reg;
            rem_no_ack      <= |(opt_reg & `RCRFP_OPT_NOACK);
            rem_ext_timeout <= |(opt_reg & `RCRFP_OPT_EXTTO);
            rem_cmd_name    <= cmd_reg;
            rem_is_query    <= (len_reg == 16'(`RCRFP_OFF_PARAM - `RCRFP_OFF_TYPE));
         end
         if (route_ok) begin
            route_dest64 <= a64_reg;
            route_bcast  <= (a64_reg == `RCRFP_BCAST64);
            route_dest16 <= a16_reg;
            route_nhops  <= nhops_reg;
            route_hops   <= hops_flat;
         end
      end
   end

   AST_NOACK: assert property (@(posedge clk) disable iff (!reset_n)
      rem_ok |=> rem_valid && rem_no_ack == $past(opt_reg[0]))
      else $error("no-ack option not carried");
   AST_EXTTO: assert property (@(posedge clk) disable iff (!reset_n)
      rem_ok |=> rem_ext_timeout == $past(opt_reg[6]))
      else $error("extended timeout option not carried");
   AST_RESPOND: assert property (@(posedge clk) disable iff (!reset_n)
      rem_valid |-> rem_respond == (rem_frame_id != 8'h00))
      else $error("response flag disagrees with frame id");
   AST_COORD: assert property (@(posedge clk) disable iff (!reset_n)
      rem_valid |-> rem_to_coord == (rem_dest64 == 64'h0))
      else $error("coordinator flag wrong");
   AST_HOPCNT: assert property (@(posedge clk) disable iff (!reset_n)
      route_valid |-> route_nhops != 8'h00 && route_nhops <= `RCRFP_MAX_HOPS)
      else $error("route accepted with bad hop count");
   AST_TABLE: assert property (@(posedge clk) disable iff (!reset_n)
      route_valid |-> route_nhops <= `RCRFP_TABLE_SIZE)
      else $error("route exceeds table size");
   AST_EXCL: assert property (@(posedge clk) disable iff (!reset_n)
      !(route_valid && rem_valid) && !(frame_drop && (route_valid || rem_valid)))
      else $error("frame both accepted and dropped");
   AST_CSUM: assert property (@(posedge clk) disable iff (!reset_n)
      (frame_end && !csum_ok) |=> !rem_valid && !route_valid && frame_drop)
      else $error("bad checksum frame accepted");
   AST_BCAST: assert property (@(posedge clk) disable iff (!reset_n)
      route_valid |-> route_bcast == (route_dest64 == `RCRFP_BCAST64))
      else $error("broadcast flag wrong");

   // Remembers whether any parameter byte streamed in the current frame; the checksum
   // byte may come any number of idle cycles after the last one
   logic         par_seen_reg;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         par_seen_reg <= 1'b0;
      end else if (take && state_reg == rcrfp_pkg::RCRFP_IDLE) begin
         par_seen_reg <= 1'b0;
      end else if (par_now) begin
         par_seen_reg <= 1'b1;
      end
   end

   AST_QUERY: assert property (@(posedge clk) disable iff (!reset_n)
      rem_ok |=> rem_is_query == !$past(par_seen_reg))
      else $error("query flag disagrees with parameter bytes");
endmodule : rcrfp_parser

// *** hw/rcrfp_defs.svh ***
`ifndef RCRFP_DEFS_SVH
`define RCRFP_DEFS_SVH
`define RCRFP_DELIM         8'h7E
`define RCRFP_TYPE_REMOTE   8'h17
`define RCRFP_TYPE_ROUTE    8'h21
`define RCRFP_CSUM_BASE     8'hFF
`define RCRFP_OFF_ID        16'h0004
`define RCRFP_OFF_A64_LO    16'h0005
`define RCRFP_OFF_A64_HI    16'h000C
`define RCRFP_OFF_A16_HI    16'h000D
`define RCRFP_OFF_A16_LO    16'h000E
`define RCRFP_OFF_OPT       16'h000F
`define RCRFP_OFF_CMD0      16'h0010
`define RCRFP_OFF_CMD1      16'h0011
`define RCRFP_OFF_PARAM     16'h0012
`define RCRFP_OFF_NHOPS     16'h0010
`define RCRFP_OFF_HOP0      16'h0011
`define RCRFP_OFF_TYPE      16'h0003
`define RCRFP_ROUTE_BASE_LEN 16'h000E
`define RCRFP_OPT_NOACK     8'h01
`define RCRFP_OPT_EXTTO     8'h40
`define RCRFP_TABLE_SIZE    8'h28
`define RCRFP_MAX_HOPS      8'h0B
`define RCRFP_HOP_IDX_W     4
`define RCRFP_BCAST64       64'h0000_0000_0000_FFFF
`endif

// *** hw/rcrfp_pkg.sv ***
package rcrfp_pkg;
   typedef enum logic [4:0] {
      RCRFP_IDLE = 5'h01,
      RCRFP_LENH = 5'h02,
      RCRFP_LENL = 5'h04,
      RCRFP_BODY = 5'h08,
      RCRFP_CSUM = 5'h10
   } rcrfp_state_t;
endpackage : rcrfp_pkg

// *** tb/rcrfp_host_model.sv ***
`timescale 1ns/1ps
module rcrfp_host_model (
   input  wire logic       clk,
   output logic            rx_valid,
   output logic [7:0]      rx_byte
);
   initial begin
      rx_valid = 1'b0;
      rx_byte  = 8'hA5;
   end
   // Frame is delimiter, length MSB first, body, then 0xFF minus the body sum
   task automatic send(input logic [7:0] body [$], input logic bad_csum);
      logic [7:0] sum;
      logic [7:0] frame [$];
      sum = 8'h00;
      foreach (body[i]) sum = sum + body[i];
      frame = {8'h7E, 8'(body.size() >> 8), 8'(body.size()), body};
      frame.push_back((8'hFF - sum) ^ {7'h00, bad_csum});
      foreach (frame[i]) begin
         @(posedge clk);
         #1;
         rx_valid = 1'b1;
         rx_byte  = frame[i];
      end
      @(posedge clk);
      #1;
      rx_valid = 1'b0;
      // Idle line shows the inverse so a stale byte never looks like a repeat
      rx_byte  = ~rx_byte;
   endtask : send
endmodule : rcrfp_host_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`define RCRFP_CHK(name, exp, got) begin checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("unexpected %s exp %0h got %0h", name, exp, got); end end
module testbench;
   logic clk, reset_n, rx_valid, rem_valid, rem_respond, rem_to_coord, rem_no_ack;
   logic rem_ext_timeout, rem_is_query, par_valid, par_last, route_valid, route_bcast;
   logic frame_drop, last_seen;
   logic [7:0]   rx_byte, rem_frame_id, par_byte, route_nhops;
   logic [15:0]  rem_dest16, rem_cmd_name, route_dest16;
   logic [63:0]  rem_dest64, route_dest64;
   logic [175:0] route_hops;
   logic [7:0]   par_q [$];
   int           num_errors, checks, rem_n, route_n, drop_n;

   rcrfp_parser dut_u (.clk(clk), .reset_n(reset_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rem_valid(rem_valid), .rem_frame_id(rem_frame_id), .rem_respond(rem_respond),
      .rem_dest64(rem_dest64), .rem_to_coord(rem_to_coord), .rem_dest16(rem_dest16),
      .rem_no_ack(rem_no_ack), .rem_ext_timeout(rem_ext_timeout), .rem_cmd_name(rem_cmd_name),
      .rem_is_query(rem_is_query), .par_valid(par_valid), .par_byte(par_byte),
      .par_last(par_last), .route_valid(route_valid), .route_dest64(route_dest64),
      .route_bcast(route_bcast), .route_dest16(route_dest16), .route_nhops(route_nhops),
      .route_hops(route_hops), .frame_drop(frame_drop));
   rcrfp_host_model host_u (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      rem_n   <= rem_n + int'(rem_valid === 1'b1);
      route_n <= route_n + int'(route_valid === 1'b1);
      drop_n  <= drop_n + int'(frame_drop === 1'b1);
      if (par_valid === 1'b1) par_q.push_back(par_byte);
      if (par_last === 1'b1) last_seen <= 1'b1;
   end

   task automatic conclude();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   // Sends one frame and expects exactly one outcome pulse: 0 remote, 1 route, 2 drop
   task automatic run(input logic [7:0] body [$], input logic bad, input int kind);
      int r0, t0, d0, n;
      r0 = rem_n;
      t0 = route_n;
      d0 = drop_n;
      n = 0;
      par_q.delete();
      last_seen = 1'b0;
      host_u.send(body, bad);
      while (rem_n == r0 && route_n == t0 && drop_n == d0 && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 20) begin
         num_errors++;
         $display("unexpected outcome pulse exp one got none");
         conclude();
      end else begin
         `RCRFP_CHK("rem_pulse", kind == 0, rem_n != r0)
         `RCRFP_CHK("route_pulse", kind == 1, route_n != t0)
         `RCRFP_CHK("drop_pulse", kind == 2, drop_n != d0)
      end
   endtask : run

   task automatic test_remote_write();
      run('{8'h17, 8'h01, 8'h00, 8'h13, 8'hA2, 8'h00, 8'h40, 8'h40, 8'h11, 8'h22,
            8'hFF, 8'hFE, 8'h01, 8'h42, 8'h48, 8'h01, 8'h02}, 1'b0, 0);
      `RCRFP_CHK("rem_respond", 1'b1, rem_respond)
      `RCRFP_CHK("rem_frame_id", 8'h01, rem_frame_id)
      `RCRFP_CHK("rem_dest64", 64'h0013_A200_4040_1122, rem_dest64)
      `RCRFP_CHK("rem_to_coord", 1'b0, rem_to_coord)
      `RCRFP_CHK("rem_dest16", 16'hFFFE, rem_dest16)
      `RCRFP_CHK("rem_no_ack", 1'b1, rem_no_ack)
      `RCRFP_CHK("rem_ext_timeout", 1'b0, rem_ext_timeout)
      `RCRFP_CHK("rem_cmd_name", 16'h4248, rem_cmd_name)
      `RCRFP_CHK("rem_is_query", 1'b0, rem_is_query)
      `RCRFP_CHK("par_count", 2, par_q.size())
      `RCRFP_CHK("par_byte", 8'h02, par_q[1])
      `RCRFP_CHK("par_last", 1'b1, last_seen)
   endtask : test_remote_write

   task automatic test_remote_query();
      run('{8'h17, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
            8'h12, 8'h34, 8'h40, 8'h4E, 8'h49}, 1'b0, 0);
      `RCRFP_CHK("rem_respond", 1'b0, rem_respond)
      `RCRFP_CHK("rem_to_coord", 1'b1, rem_to_coord)
      `RCRFP_CHK("rem_dest16", 16'h1234, rem_dest16)
      `RCRFP_CHK("rem_no_ack", 1'b0, rem_no_ack)
      `RCRFP_CHK("rem_ext_timeout", 1'b1, rem_ext_timeout)
      `RCRFP_CHK("rem_cmd_name", 16'h4E49, rem_cmd_name)
      `RCRFP_CHK("rem_is_query", 1'b1, rem_is_query)
      `RCRFP_CHK("par_count", 0, par_q.size())
      // Corrupted checksum, then an unknown type: neither may touch the held fields
      run('{8'h17, 8'h05, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
            8'hFF, 8'hFE, 8'h01, 8'h41, 8'h42}, 1'b1, 2);
      run('{8'h08, 8'h01, 8'h42, 8'h44}, 1'b0, 2);
      `RCRFP_CHK("rem_frame_id", 8'h00, rem_frame_id)
   endtask : test_remote_query

   task automatic test_route(input int n, input logic [63:0] dest, input int kind);
      logic [7:0] body [$];
      body = '{8'h21, 8'h00};
      for (int i = 7; i >= 0; i--) body.push_back(dest[8*i +: 8]);
      body = {body, 8'h33, 8'h44, 8'h00, 8'(n)};
      for (int k = 0; k < n; k++) body = {body, 8'hB0 + 8'(k), 8'hC0 + 8'(k)};
      run(body, 1'b0, kind);
      if (kind == 1) begin
         `RCRFP_CHK("route_dest64", dest, route_dest64)
         `RCRFP_CHK("route_bcast", dest == 64'h0000_0000_0000_FFFF, route_bcast)
         `RCRFP_CHK("route_dest16", 16'h3344, route_dest16)
         `RCRFP_CHK("route_nhops", 8'(n), route_nhops)
         `RCRFP_CHK("hop_first", 16'hB0C0, route_hops[15:0])
         `RCRFP_CHK("hop_last", {8'hB0 + 8'(n - 1), 8'hC0 + 8'(n - 1)},
                    route_hops[16*(n-1) +: 16])
      end
   endtask : test_route

   initial begin
      num_errors = 0;
      checks = 0;
      rem_n = 0;
      route_n = 0;
      drop_n = 0;
      last_seen = 1'b0;
      reset_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      reset_n = 1'b1;
      `RCRFP_CHK("idle_pulses", 3'b000, {rem_valid, route_valid, frame_drop})
      test_remote_write();
      test_remote_query();
      test_route(3, 64'h0013_A200_4040_1122, 1);
      test_route(11, 64'h0000_0000_0000_FFFF, 1);
      test_route(12, 64'h0013_A200_4040_1122, 2);
      test_route(0, 64'h0013_A200_4040_1122, 2);
      test_route(41, 64'h0013_A200_4040_1122, 2);
      conclude();
   end
endmodule : testbench
